/* File: verilog/fault_protect_pkg.sv */
// Shared constants for the PWM protection and hiccup sequencing logic.
// Assumes a single 50 MHz clock and comparator results as one-bit inputs.
package fault_protect_pkg;
   localparam int CLK_PERIOD_NS = 20;
   // Leading-edge blanking after a primary drive goes high.
   localparam int BLANK_TIME_NS = 70;
   localparam int BLANK_CYCLES  =
      (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BLANK_W       = 3;
   // Internal oscillator period in clocks; outputs A and B take alternate whole periods.
   localparam int SWITCH_PERIOD_CYCLES = 100;
   localparam int PERIOD_W             = 7;
   // Timer widths; terminal counts arrive on input ports.
   localparam int TIMER_W        = 24;
   // Fast charge phase is a fraction of the slow discharge phase.
   localparam int HICCUP_TIMING_NODE_CHARGE_SHIFT = 8;
   // Input synchroniser lane positions.
   localparam int SYN_LIMIT    = 0;
   localparam int SYN_PWMEND   = 1;
   localparam int SYN_FAULT    = 2;
   localparam int SYN_SSLOW    = 3;
   localparam int SYN_VALID    = 4;
   localparam int SYN_W        = 5;
   typedef enum logic [1:0] {
      RUN,
      FAULT_HOLD,
      HICCUP_TIMING_NODE_CHARGE,
      HICCUP_TIMING_NODE_DISCHARGE
   } protect_state_t;
endpackage

/* File: verilog/protect_timer_if.sv */
// Carrier between the drive core and the protection timer.
// Assumes both ends share clk.
`timescale 1ns/10ps
interface protect_timer_if;
   logic                                     limiting;
   logic                                     faultLevel;
   logic                                     externalOff;
   logic [fault_protect_pkg::TIMER_W-1:0]    ocDelayTerminal;
   logic [fault_protect_pkg::TIMER_W-1:0]    hiccupTerminal;
   logic                                     outputsOff;
   logic                                     ssHold;
   logic                                     chargeFast;
   logic                                     dischargeSlow;
   logic                                     faultActive;
   logic                                     holdNext;
   modport core (
      output limiting, faultLevel, externalOff, ocDelayTerminal,
      output hiccupTerminal,
      input  outputsOff, ssHold, chargeFast, dischargeSlow, faultActive,
      input  holdNext
   );
   modport timer (
      input  limiting, faultLevel, externalOff, ocDelayTerminal,
      input  hiccupTerminal,
      output outputsOff, ssHold, chargeFast, dischargeSlow, faultActive,
      output holdNext
   );
endinterface

/* File: verilog/protect_timer.sv */
// Overcurrent delay timer, fault hold and hiccup restart sequencer.
// Assumes limiting is a level that is high while pulses end on current limit.
`timescale 1ns/10ps
module protect_timer (
   input wire logic        clk,
   input wire logic        reset_n,
   protect_timer_if.timer  tif
);
   fault_protect_pkg::protect_state_t state_q;
   logic [fault_protect_pkg::TIMER_W-1:0] delay_q;
   logic [fault_protect_pkg::TIMER_W-1:0] hiccup_timing_node_q;
   logic [fault_protect_pkg::TIMER_W-1:0] chargeTerm;
   logic                                  ocExpired;

   assign chargeTerm =
      tif.hiccupTerminal >> fault_protect_pkg::HICCUP_TIMING_NODE_CHARGE_SHIFT;
   assign ocExpired  = tif.limiting && (delay_q >= tif.ocDelayTerminal);
   // The core reads the next hold value so that charge and hold never overlap.
   assign tif.holdNext = (state_q != fault_protect_pkg::RUN)
                         || ocExpired || tif.faultLevel;

   // Counting back down keeps brief overloads from adding up forever.
   always_ff @(posedge clk) begin
      if (!reset_n || state_q != fault_protect_pkg::RUN) begin
         delay_q <= '0;
      end else if (tif.limiting) begin
         delay_q <= delay_q + 1'b1;
      end else if (delay_q != '0) begin
         delay_q <= delay_q - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_q <= fault_protect_pkg::RUN;
         hiccup_timing_node_q  <= '0;
      end else begin
         case (state_q)
            fault_protect_pkg::RUN: begin
               hiccup_timing_node_q <= '0;
               if (tif.faultLevel) begin
                  state_q <= fault_protect_pkg::FAULT_HOLD;
               end else if (ocExpired) begin
                  state_q <= fault_protect_pkg::HICCUP_TIMING_NODE_CHARGE;
               end
            end
            fault_protect_pkg::FAULT_HOLD: begin
               if (!tif.faultLevel) begin
                  state_q <= fault_protect_pkg::HICCUP_TIMING_NODE_CHARGE;
               end
            end
            fault_protect_pkg::HICCUP_TIMING_NODE_CHARGE: begin
               if (tif.faultLevel) begin
                  state_q <= fault_protect_pkg::FAULT_HOLD;
               end else if (hiccup_timing_node_q >= chargeTerm) begin
                  hiccup_timing_node_q  <= '0;
                  state_q <= fault_protect_pkg::HICCUP_TIMING_NODE_DISCHARGE;
               end else begin
                  hiccup_timing_node_q <= hiccup_timing_node_q + 1'b1;
               end
            end
            fault_protect_pkg::HICCUP_TIMING_NODE_DISCHARGE: begin
               if (tif.faultLevel) begin
                  state_q <= fault_protect_pkg::FAULT_HOLD;
               end else if (hiccup_timing_node_q >= tif.hiccupTerminal) begin
                  state_q <= fault_protect_pkg::RUN;
               end else begin
                  hiccup_timing_node_q <= hiccup_timing_node_q + 1'b1;
               end
            end
            default: begin
               state_q <= fault_protect_pkg::RUN;
            end
         endcase
      end
   end

   // Outputs other than holdNext are registered so the top can pass them straight out.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tif.outputsOff    <= 1'b1;
         tif.ssHold        <= 1'b1;
         tif.chargeFast    <= 1'b0;
         tif.dischargeSlow <= 1'b0;
         tif.faultActive   <= 1'b0;
      end else begin
         tif.outputsOff    <= (state_q != fault_protect_pkg::RUN)
                              || tif.externalOff;
         tif.ssHold        <= tif.holdNext;
         tif.chargeFast    <= (state_q == fault_protect_pkg::HICCUP_TIMING_NODE_CHARGE);
         tif.dischargeSlow <= (state_q == fault_protect_pkg::HICCUP_TIMING_NODE_DISCHARGE);
         tif.faultActive   <= (state_q == fault_protect_pkg::FAULT_HOLD);
      end
   end
endmodule // protect_timer

/* File: verilog/pwm_fault_protect_hiccup.sv */
// Drive core with current limit, blanking and fault sequencing.
// Assumes analog comparators feed one-bit pins; terminal counts are static.
`timescale 1ns/10ps
module pwm_fault_protect_hiccup (
   input  wire logic                                  clk,
   input  wire logic                                  reset_n,
   input  wire logic                                  currentLimitSense,
   input  wire logic                                  pwmTerminate,
   input  wire logic                                  faultProtectSense,
   input  wire logic                                  softStartLow,
   input  wire logic                                  operatingValid,
   input  wire logic [fault_protect_pkg::TIMER_W-1:0] ocDelayCount,
   input  wire logic [fault_protect_pkg::TIMER_W-1:0] hiccupCount,
   output logic                                       primaryDriveA,
   output logic                                       primaryDriveB,
   output logic                                       rectifierDriveA,
   output logic                                       rectifierDriveB,
   output logic                                       senseDischarge,
   output logic                                       softStartDischarge,
   output logic                                       softStartCharge,
   output logic                                       hiccupChargeFast,
   output logic                                       hiccupDischargeSlow,
   output logic                                       faultHysteresisOn,
   output logic                                       limitModeActive
);
   logic [fault_protect_pkg::SYN_W-1:0]    syncA_q;
   logic [fault_protect_pkg::SYN_W-1:0]    syncB_q;
   logic [fault_protect_pkg::PERIOD_W-1:0] period_q;
   logic [fault_protect_pkg::BLANK_W-1:0]  blank_q;
   logic                                   cycleStart;
   logic                                   phaseB_q;
   logic                                   pulseOn_q;
   logic                                   limitedThis_q;
   logic                                   limitedLast_q;
   logic                                   limitTrip;
   logic                                   pwmEnd;
   logic                                   runAllowed;
   logic                                   ssCharge_q;
   protect_timer_if                        tif ();

   // Asynchronous pins go through two flip-flops before any logic reads them.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         syncA_q <= '0;
         syncB_q <= '0;
      end else begin
         syncA_q <= {operatingValid, softStartLow, faultProtectSense,
                     pwmTerminate, currentLimitSense};
         syncB_q <= syncA_q;
      end
   end

   // Switching oscillator; a cycle starts when the counter wraps.
   assign cycleStart = (period_q == '0);
   always_ff @(posedge clk) begin
      if (!reset_n || period_q ==
          fault_protect_pkg::PERIOD_W'(fault_protect_pkg::SWITCH_PERIOD_CYCLES
                                       - 1)) begin
         period_q <= '0;
      end else begin
         period_q <= period_q + 1'b1;
      end
   end

   // Trip is ignored while the sense node is being blanked.
   assign limitTrip = syncB_q[fault_protect_pkg::SYN_LIMIT]
                      && !senseDischarge && pulseOn_q;
   // The same comparator ends pulses whether the shared input is a ramp
   // or a current signal.
   assign pwmEnd    = syncB_q[fault_protect_pkg::SYN_PWMEND];
   assign runAllowed = !tif.outputsOff
                       && syncB_q[fault_protect_pkg::SYN_VALID];

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         senseDischarge <= 1'b1;
         blank_q        <= '0;
      end else if (cycleStart) begin
         senseDischarge <= 1'b1;
         blank_q        <= fault_protect_pkg::BLANK_W'
                           (fault_protect_pkg::BLANK_CYCLES);
      end else if (blank_q != '0) begin
         blank_q        <= blank_q - 1'b1;
      end else begin
         senseDischarge <= 1'b0;
      end
   end

   // Pulse on at cycle start, off on limit or normal PWM end.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pulseOn_q <= 1'b0;
         phaseB_q  <= 1'b0;
      end else if (cycleStart) begin
         pulseOn_q <= runAllowed;
         phaseB_q  <= !phaseB_q;
      end else if (limitTrip || pwmEnd || !runAllowed) begin
         pulseOn_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         limitedThis_q <= 1'b0;
         limitedLast_q <= 1'b0;
      end else if (cycleStart) begin
         limitedThis_q <= 1'b0;
         limitedLast_q <= limitedThis_q;
      end else if (limitTrip) begin
         limitedThis_q <= 1'b1;
      end
   end

   // Every drive output is gated by the same shutdown term.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         primaryDriveA   <= 1'b0;
         primaryDriveB   <= 1'b0;
         rectifierDriveA <= 1'b0;
         rectifierDriveB <= 1'b0;
         limitModeActive <= 1'b0;
      end else begin
         primaryDriveA   <= pulseOn_q && !phaseB_q && runAllowed;
         primaryDriveB   <= pulseOn_q && phaseB_q && runAllowed;
         rectifierDriveA <= !(pulseOn_q && !phaseB_q) && runAllowed;
         rectifierDriveB <= !(pulseOn_q && phaseB_q) && runAllowed;
         limitModeActive <= limitedThis_q || limitedLast_q;
      end
   end

   // Charging stops whenever the node is held, so the two never fight.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ssCharge_q <= 1'b0;
      end else begin
         ssCharge_q <= syncB_q[fault_protect_pkg::SYN_VALID]
                       && !tif.holdNext;
      end
   end

   assign tif.limiting        = limitedThis_q || limitedLast_q;
   assign tif.faultLevel      = syncB_q[fault_protect_pkg::SYN_FAULT];
   assign tif.externalOff     = syncB_q[fault_protect_pkg::SYN_SSLOW]
                                && ssCharge_q;
   assign tif.ocDelayTerminal = ocDelayCount;
   assign tif.hiccupTerminal  = hiccupCount;

   assign softStartDischarge  = tif.ssHold;
   assign softStartCharge     = ssCharge_q;
   assign hiccupChargeFast    = tif.chargeFast;
   assign hiccupDischargeSlow = tif.dischargeSlow;
   // Extra source current while faulted lowers the recovery level.
   assign faultHysteresisOn   = tif.faultActive;

   protect_timer timer (
      .clk     (clk),
      .reset_n (reset_n),
      .tif     (tif)
   );
endmodule // pwm_fault_protect_hiccup

/* File: verification/pwm_fault_protect_hiccup_chk.sv */
// Concurrent checks on the pins of the protection and hiccup block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
module pwm_fault_protect_hiccup_chk (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic currentLimitSense,
   input wire logic faultProtectSense,
   input wire logic primaryDriveA,
   input wire logic primaryDriveB,
   input wire logic rectifierDriveA,
   input wire logic rectifierDriveB,
   input wire logic senseDischarge,
   input wire logic softStartDischarge,
   input wire logic softStartCharge,
   input wire logic hiccupChargeFast,
   input wire logic hiccupDischargeSlow,
   input wire logic faultHysteresisOn,
   input wire logic limitModeActive
);
   wire logic       anyDrive = primaryDriveA || primaryDriveB;
   wire logic [3:0] drives   = {primaryDriveA, primaryDriveB,
                                rectifierDriveA, rectifierDriveB};
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Two samples are needed because the trip pin is asynchronous.
   sequence tripSeq;
      (currentLimitSense && !senseDischarge)[*2];
   endsequence
   sequence faultSeq;
      faultProtectSense[*7];
   endsequence
   sequence hiccSeq;
      (hiccupChargeFast || hiccupDischargeSlow)[*3];
   endsequence
   AST_ONE_PRIMARY: assert property (!(primaryDriveA && primaryDriveB))
      else $error("both primary drives high together");
   AST_RECT_OFF: assert property (!(primaryDriveA && rectifierDriveA) &&
      !(primaryDriveB && rectifierDriveB))
      else $error("rectifier drive overlaps its primary drive");
   AST_SS_EXCL: assert property (softStartDischarge |-> !softStartCharge)
      else $error("soft-start charged while held low");
   AST_HICCUP_TIMING_NODE_EXCL: assert property (!(hiccupChargeFast && hiccupDischargeSlow))
      else $error("hiccup charge and discharge together");
   AST_HICCUP_TIMING_NODE_OFF: assert property (hiccSeq |-> drives == 4'h0 && softStartDischarge)
      else $error("drives or soft-start active during hiccup");
   AST_PHASE_ORDER: assert property ($rose(hiccupDischargeSlow) |-> $past(hiccupChargeFast))
      else $error("slow discharge not preceded by fast charge");
   AST_FAULT_OFF: assert property (faultSeq |-> drives == 4'h0 && softStartDischarge)
      else $error("drives not stopped by fault input");
   AST_HYST: assert property (faultSeq |-> faultHysteresisOn)
      else $error("hysteresis source off during fault");
   AST_DISCH_FIRST: assert property ($rose(anyDrive) |-> $past(senseDischarge))
      else $error("sense not discharged at cycle start");
   AST_BLANK: assert property ($rose(anyDrive) |-> senseDischarge[*3])
      else $error("blanking shorter than required");
   AST_TRIP_END: assert property (tripSeq |-> ##[1:5] !anyDrive)
      else $error("current trip did not end the pulse");
   AST_LIMIT: assert property (tripSeq |-> ##[1:6] limitModeActive)
      else $error("limit mode not flagged after trip");
endmodule // pwm_fault_protect_hiccup_chk
bind pwm_fault_protect_hiccup pwm_fault_protect_hiccup_chk u_chk (
   .clk, .reset_n, .currentLimitSense, .faultProtectSense, .primaryDriveA,
   .primaryDriveB, .rectifierDriveA, .rectifierDriveB, .senseDischarge,
   .softStartDischarge, .softStartCharge, .hiccupChargeFast,
   .hiccupDischargeSlow, .faultHysteresisOn, .limitModeActive);

/* File: verification/sense_network_model.sv */
// Model of the analog sense comparators outside the block.
// Assumes drive pins from the block and levels from the bench.
`timescale 1ns/10ps
module sense_network_model (
   input  wire logic        clk,
   input  wire logic        primaryDriveA,
   input  wire logic        primaryDriveB,
   input  wire logic        senseDischarge,
   input  wire logic        faultHysteresisOn,
   input  wire logic        overload,
   input  wire logic [11:0] faultMv,
   output logic             currentLimitSense = 1'b0,
   output logic             pwmTerminate = 1'b0,
   output logic             faultProtectSense = 1'b0
);
   logic on;
   logic [7:0] onTime = 8'h00;
   assign on = primaryDriveA || primaryDriveB;
   // Levels move on the falling edge, away from the block's sampling edge.
   always @(negedge clk) begin
      onTime <= on ? onTime + 8'h01 : 8'h00;
      // The pull-down switch always wins over the sensed current.
      currentLimitSense <= overload && on && onTime >= 8'h13 &&
         !senseDischarge;
      pwmTerminate <= onTime >= 8'h2C;
      // The switched source lifts the pin while a fault is held.
      faultProtectSense <= faultMv + (faultHysteresisOn ? 12'h064 :
         12'h000) > 12'h2BC;
   end
endmodule // sense_network_model

/* File: verification/tb.sv */
// Self-checking bench for the protection and hiccup block.
// Assumes the sense model supplies the comparator pins.
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
   localparam int W = fault_protect_pkg::TIMER_W;
   logic         clk = 1'b0;
   logic         reset_n = 1'b0;
   logic         overload = 1'b0;
   logic         softStartLow = 1'b0;
   logic         operatingValid = 1'b0;
   logic         hSeen = 1'b0;
   logic [11:0]  faultMv = 12'h000;
   logic [W-1:0] oc = '0;
   logic [W-1:0] hc = '0;
   logic         currentLimitSense, pwmTerminate, faultProtectSense;
   logic         pA, pB, rA, rB, senseDis, ssDis, ssChg;
   logic         hFast, hSlow, hyst, lim;
   logic [3:0]   prev = 4'h0;
   wire  [3:0]   drv = {rB, rA, pB, pA};
   int           num_errors = 0, checks = 0, ticks = 0, width = 0;
   int           lastW = 0, n = 0;
   int           rise [4] = '{default: 0};
   pwm_fault_protect_hiccup DUT (.clk, .reset_n, .currentLimitSense,
      .pwmTerminate, .faultProtectSense, .softStartLow, .operatingValid,
      .ocDelayCount(oc), .hiccupCount(hc), .primaryDriveA(pA),
      .primaryDriveB(pB), .rectifierDriveA(rA), .rectifierDriveB(rB),
      .senseDischarge(senseDis), .softStartDischarge(ssDis),
      .softStartCharge(ssChg), .hiccupChargeFast(hFast),
      .hiccupDischargeSlow(hSlow), .faultHysteresisOn(hyst),
      .limitModeActive(lim));
   sense_network_model PM (.clk, .primaryDriveA(pA), .primaryDriveB(pB),
      .senseDischarge(senseDis), .faultHysteresisOn(hyst), .overload,
      .faultMv, .currentLimitSense, .pwmTerminate, .faultProtectSense);
   initial forever #10 clk = ~clk;
   function automatic int expCharge(int h);
      return (h >> 8) + 1;
   endfunction
   function automatic int expDisch(int h);
      return h + 1;
   endfunction
   task automatic cyc(int k);
      repeat (k) @(negedge clk);
   endtask
   task automatic wrap_up();
      $display("checks=%0d errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Waits for one hiccup period and measures both of its phases.
   task automatic hiccup(int lim);
      int k;
      k = 0;
      while (hFast !== 1'b1 && k < lim) begin cyc(1); k++; end
      `CHK(hFast, 1'b1)
      k = 0;
      do begin k++; cyc(1); end while (hFast === 1'b1);
      `CHK(k, expCharge(hc))
      `CHK({drv, ssDis, ssChg, hSlow}, 7'h05)
      k = 0;
      do begin k++; cyc(1); end while (hSlow === 1'b1);
      `CHK(k, expDisch(hc))
      k = 0;
      while (ssChg !== 1'b1 && k < 10) begin cyc(1); k++; end
      `CHK(ssChg, 1'b1)
   endtask
   always @(posedge clk) begin
      ticks++;
      if (ticks == 40000) begin num_errors++; wrap_up(); end
      for (int i = 0; i < 4; i++) if (drv[i] && !prev[i]) rise[i]++;
      prev = drv;
      if (hFast === 1'b1) hSeen = 1'b1;
      if (pA || pB) width++;
      else begin if (width > 0) lastW = width; width = 0; end
   end
   initial begin
      void'($urandom(32'hD036));
      oc = W'(600 + $urandom % 100);
      hc = W'(512 + $urandom % 512);
      cyc(6);
      reset_n = 1'b1;
      operatingValid = 1'b1;
      cyc(1000);
      `CHK(rise[0] > 3 && rise[1] > 3, 1'b1)
      `CHK(rise[2] > 2 && rise[3] > 2, 1'b1)
      `CHK({ssChg, lim, lastW > 40}, 3'h5)
      $display("test normal finished");
      // Bursts that would add up past the delay if the count never fell.
      repeat (2) begin
         overload = 1'b1;
         cyc(350);
         `CHK({lim, lastW < 32}, 2'h3)
         overload = 1'b0;
         cyc(800);
      end
      `CHK(hSeen, 1'b0)
      $display("test burst finished");
      overload = 1'b1;
      while (lim !== 1'b1 && n < 300) begin cyc(1); n++; end
      n = 0;
      while (hFast !== 1'b1 && n < 2000) begin cyc(1); n++; end
      `CHK(n + 3 >= oc && n <= oc + 6, 1'b1)
      overload = 1'b0;
      hiccup(5);
      $display("test overcurrent finished");
      cyc(300);
      faultMv = 12'(701 + $urandom % 300);
      cyc(20);
      `CHK({drv, ssDis, ssChg, hyst}, 7'h05)
      // Below the trip level but held by the hysteresis source.
      faultMv = 12'h28A;
      cyc(30);
      `CHK({hyst, hFast}, 2'h2)
      faultMv = 12'(100 + $urandom % 400);
      hiccup(10);
      $display("test fault finished");
      cyc(300);
      softStartLow = 1'b1;
      cyc(10);
      `CHK({pA, pB, ssChg}, 3'h1)
      softStartLow = 1'b0;
      n = 0;
      while (ssChg !== 1'b1 && n < 3000) begin cyc(1); n++; end
      `CHK(ssChg, 1'b1)
      $display("test external finished");
      wrap_up();
   end
endmodule // tb
